// File: src/jlr_ctrl_regs.sv
// axi4-lite register bank: core reset control, alignment sequence and scrambler enables,
// timing-reference handling and the resync wait that the handling options steer
// assumes synchronous inputs on clk_sys and aligned 32-bit axi4-lite accesses
`timescale 1ns/100ps
module jlr_ctrl_regs #(
    parameter int ADDR_W     = 12,
    parameter int RST_CYCLES = jlr_pkg::RST_HOLD_CYCLES
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              tref_in,
    input  wire logic              lmfc_boundary,
    input  wire logic              link_resync,
    output logic                   core_rst,
    output jlr_pkg::jlr_cfg_t      link_cfg,
    output logic                   align_hold,
    output logic                   link_go,
    output logic                   lmfc_realign
);

    // parameter values the decode or the counter cannot serve stop elaboration
    if (ADDR_W < 5 || ADDR_W > 12) begin : g_bad_addr_w
        $error("address width must be 5 to 12");
    end
    if (RST_CYCLES < 1 || RST_CYCLES > 65535) begin : g_bad_rst_cycles
        $error("reset length out of range");
    end

    localparam int CW = $clog2(RST_CYCLES + 1);
    localparam logic [CW-1:0] RST_LOAD = CW'(RST_CYCLES);
    localparam logic [31:0] RSV_MASK = 32'hFFFE_F0FC;

    typedef struct packed {
        logic                  fixed_rst;
        logic [CW-1:0]         rst_cnt;
        logic                  core_rst;
        logic                  wd_dis;
        logic                  align_en;
        logic                  scram_en;
        logic                  tref_req;
        logic [3:0]            tref_dly;
        logic                  tref_alw;
        jlr_pkg::jlr_sync_st_t sync;
        logic                  hold;
        logic                  go;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic [31:0]           rdata;
    } jlr_main_st_t;

    jlr_main_st_t          st_reg;
    jlr_main_st_t          st_next;
    logic                  wr_fire;
    logic                  rd_fire;
    logic [11:0]           wa;
    logic [11:0]           ra;
    jlr_pkg::jlr_tref_cfg_t tref_cfg;

    assign tref_cfg = '{always_realign: st_reg.tref_alw, delay: st_reg.tref_dly};

    // timing-reference path lives in its own block
    jlr_tref_align #(
        .MAX_DLY (jlr_pkg::TREF_DLY_MAX)
    ) u_tref (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .core_rst     (st_reg.core_rst),
        .tref_in      (tref_in),
        .cfg          (tref_cfg),
        .lmfc_realign (lmfc_realign)
    );

    // write channel takes address and data together; one response outstanding keeps it simple
    assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !st_reg.bvalid;
    assign rd_fire       = s_axi_arvalid && !st_reg.rvalid;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign s_axi_arready = rd_fire;
    assign wa            = 12'(s_axi_awaddr);
    assign ra            = 12'(s_axi_araddr);

    // next-state logic: bus, reset sequencer, resync wait
    always_comb begin
        st_next    = st_reg;
        st_next.go = 1'b0;
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        // held fixed reset reloads the counter so the full sequence runs after release
        if (st_reg.fixed_rst) begin
            st_next.rst_cnt = RST_LOAD;
        end else if (st_reg.rst_cnt != '0) begin
            st_next.rst_cnt = st_reg.rst_cnt - CW'(1);
        end
        // one decode serves both link directions
        if (wr_fire) begin
            st_next.bvalid = 1'b1;
            st_next.bresp  = jlr_pkg::RESP_OKAY;
            if (wa == jlr_pkg::ADDR_RESET) begin
                if (s_axi_wstrb[0]) begin
                    st_next.fixed_rst = s_axi_wdata[jlr_pkg::RST_FIX_BIT];
                    if (s_axi_wdata[jlr_pkg::RST_SC_BIT]) begin
                        st_next.rst_cnt = RST_LOAD;
                    end
                end
                if (s_axi_wstrb[2]) begin
                    st_next.wd_dis = s_axi_wdata[jlr_pkg::RST_WD_BIT];
                end
            end else if (wa == jlr_pkg::ADDR_ALIGN) begin
                if (s_axi_wstrb[0]) begin
                    st_next.align_en = s_axi_wdata[jlr_pkg::ALIGN_EN_BIT];
                end
            end else if (wa == jlr_pkg::ADDR_SCRAM) begin
                if (s_axi_wstrb[0]) begin
                    st_next.scram_en = s_axi_wdata[jlr_pkg::SCRAM_EN_BIT];
                end
            end else if (wa == jlr_pkg::ADDR_TREF) begin
                if (s_axi_wstrb[0]) begin
                    st_next.tref_alw = s_axi_wdata[jlr_pkg::TREF_ALW_BIT];
                end
                if (s_axi_wstrb[1]) begin
                    st_next.tref_dly = s_axi_wdata[jlr_pkg::TREF_DLY_LSB +: jlr_pkg::TREF_DLY_W];
                end
                if (s_axi_wstrb[2]) begin
                    st_next.tref_req = s_axi_wdata[jlr_pkg::TREF_REQ_BIT];
                end
            end else begin
                st_next.bresp = jlr_pkg::RESP_SLVERR;            // unmapped: no effect
            end
        end
        // config fields are untouched by the reset sequencer
        st_next.core_rst = st_next.fixed_rst || (st_next.rst_cnt != '0);
        // read data registered; reserved bits stay zero
        if (rd_fire) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = jlr_pkg::RESP_OKAY;
            st_next.rdata  = 32'h0000_0000;
            if (ra == jlr_pkg::ADDR_RESET) begin
                st_next.rdata[jlr_pkg::RST_SC_BIT]  = st_reg.core_rst;
                st_next.rdata[jlr_pkg::RST_FIX_BIT] = st_reg.fixed_rst;
                st_next.rdata[jlr_pkg::RST_WD_BIT]  = st_reg.wd_dis;
            end else if (ra == jlr_pkg::ADDR_ALIGN) begin
                st_next.rdata[jlr_pkg::ALIGN_EN_BIT] = st_reg.align_en;
            end else if (ra == jlr_pkg::ADDR_SCRAM) begin
                st_next.rdata[jlr_pkg::SCRAM_EN_BIT] = st_reg.scram_en;
            end else if (ra == jlr_pkg::ADDR_TREF) begin
                st_next.rdata[jlr_pkg::TREF_ALW_BIT]                          = st_reg.tref_alw;
                st_next.rdata[jlr_pkg::TREF_DLY_LSB +: jlr_pkg::TREF_DLY_W]   = st_reg.tref_dly;
                st_next.rdata[jlr_pkg::TREF_REQ_BIT]                          = st_reg.tref_req;
            end else begin
                st_next.rresp = jlr_pkg::RESP_SLVERR;
            end
        end
        // resync wait: either for a realignment first, or straight to the next boundary
        case (st_reg.sync)
            jlr_pkg::sync_run: begin
                if (link_resync) begin
                    st_next.sync = st_reg.tref_req ? jlr_pkg::sync_wait_tref : jlr_pkg::sync_wait_lmfc;
                end
            end
            jlr_pkg::sync_wait_tref: begin
                if (lmfc_realign) begin
                    st_next.sync = jlr_pkg::sync_wait_lmfc;
                end
            end
            jlr_pkg::sync_wait_lmfc: begin
                if (lmfc_boundary) begin
                    st_next.sync = jlr_pkg::sync_run;
                    st_next.go   = 1'b1;
                end
            end
            default: begin
                st_next.sync = jlr_pkg::sync_wait_lmfc;
            end
        endcase
        // a core reset is a restart: the link re-synchronises with current settings
        if (st_reg.core_rst) begin
            st_next.sync = st_reg.tref_req ? jlr_pkg::sync_wait_tref : jlr_pkg::sync_wait_lmfc;
            st_next.go   = 1'b0;
        end
        st_next.hold = (st_next.sync != jlr_pkg::sync_run);
    end

    // state register; power-up starts a self-clearing reset, as bit 0 reads one by default
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_reg           <= '0;
            st_reg.fixed_rst <= jlr_pkg::RST_FIX_RST;
            st_reg.rst_cnt   <= RST_LOAD;
            st_reg.core_rst  <= jlr_pkg::RST_SC_RST;
            st_reg.wd_dis    <= jlr_pkg::RST_WD_RST;
            st_reg.align_en  <= jlr_pkg::ALIGN_EN_RST;
            st_reg.scram_en  <= jlr_pkg::SCRAM_EN_RST;
            st_reg.tref_req  <= jlr_pkg::TREF_REQ_RST;
            st_reg.tref_dly  <= jlr_pkg::TREF_DLY_RST;
            st_reg.tref_alw  <= jlr_pkg::TREF_ALW_RST;
            st_reg.sync      <= jlr_pkg::sync_wait_lmfc;
            st_reg.hold      <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from state flops
    assign core_rst                  = st_reg.core_rst;
    assign link_cfg.watchdog_disable = st_reg.wd_dis;
    assign link_cfg.align_seq_enable = st_reg.align_en;
    assign link_cfg.scrambler_enable = st_reg.scram_en;
    assign align_hold                = st_reg.hold;
    assign link_go                   = st_reg.go;
    assign s_axi_bvalid              = st_reg.bvalid;
    assign s_axi_bresp               = st_reg.bresp;
    assign s_axi_rvalid              = st_reg.rvalid;
    assign s_axi_rresp               = st_reg.rresp;
    assign s_axi_rdata               = st_reg.rdata;

    property p_fixed_hold;
        @(posedge clk_sys) disable iff (!reset_n)
        st_reg.fixed_rst |-> core_rst ##1 (core_rst || st_reg.fixed_rst);
    endproperty
    a_fixed_hold: assert property (p_fixed_hold) else $error("core left reset while fixed bit set");

    property p_sc_start;
        @(posedge clk_sys) disable iff (!reset_n)
        (wr_fire && wa == jlr_pkg::ADDR_RESET && s_axi_wstrb[0] && s_axi_wdata[jlr_pkg::RST_SC_BIT])
        |=> (core_rst && st_reg.rst_cnt == RST_LOAD);
    endproperty
    a_sc_start: assert property (p_sc_start) else $error("self-clearing reset not started");

    property p_sc_end;
        @(posedge clk_sys) disable iff (!reset_n)
        $fell(core_rst) |-> ($past(st_reg.rst_cnt) == CW'(1) && !st_reg.fixed_rst);
    endproperty
    a_sc_end: assert property (p_sc_end) else $error("reset ended early");

    property p_cfg_kept;
        @(posedge clk_sys) disable iff (!reset_n)
        !wr_fire |=> ($stable(link_cfg) && $stable(st_reg.tref_dly) && $stable(st_reg.tref_req));
    endproperty
    a_cfg_kept: assert property (p_cfg_kept) else $error("config changed without a write");

    property p_wd_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (wr_fire && wa == jlr_pkg::ADDR_RESET && s_axi_wstrb[2])
        |=> link_cfg.watchdog_disable == $past(s_axi_wdata[jlr_pkg::RST_WD_BIT]);
    endproperty
    a_wd_write: assert property (p_wd_write) else $error("watchdog disable not written");

    property p_align_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (wr_fire && wa == jlr_pkg::ADDR_ALIGN && s_axi_wstrb[0])
        |=> link_cfg.align_seq_enable == $past(s_axi_wdata[jlr_pkg::ALIGN_EN_BIT]);
    endproperty
    a_align_write: assert property (p_align_write) else $error("alignment enable not written");

    property p_scram_write;
        @(posedge clk_sys) disable iff (!reset_n)
        (wr_fire && wa == jlr_pkg::ADDR_SCRAM && s_axi_wstrb[0])
        |=> link_cfg.scrambler_enable == $past(s_axi_wdata[jlr_pkg::SCRAM_EN_BIT]);
    endproperty
    a_scram_write: assert property (p_scram_write) else $error("scrambler enable not written");

    property p_req_wait;
        @(posedge clk_sys) disable iff (!reset_n)
        (st_reg.sync == jlr_pkg::sync_wait_tref && !lmfc_realign) |=> (align_hold && !link_go);
    endproperty
    a_req_wait: assert property (p_req_wait) else $error("link proceeded before realignment");

    property p_boundary_go;
        @(posedge clk_sys) disable iff (!reset_n)
        (st_reg.sync == jlr_pkg::sync_wait_lmfc && lmfc_boundary && !core_rst) |=> (link_go && !align_hold);
    endproperty
    a_boundary_go: assert property (p_boundary_go) else $error("link not released at boundary");

    property p_rsv_zero;
        @(posedge clk_sys) disable iff (!reset_n)
        s_axi_rvalid |-> ((s_axi_rdata & RSV_MASK) == 32'h0000_0000);
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit read nonzero");

    property p_resp_hold;
        @(posedge clk_sys) disable iff (!reset_n)
        (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp));
    endproperty
    a_resp_hold: assert property (p_resp_hold) else $error("read answer dropped under stall");

    c_resync_tref: cover property (@(posedge clk_sys) disable iff (!reset_n)
        st_reg.sync == jlr_pkg::sync_wait_tref ##[1:100] link_go);
    c_sc_reset: cover property (@(posedge clk_sys) disable iff (!reset_n) $fell(core_rst));
    c_unmapped: cover property (@(posedge clk_sys) disable iff (!reset_n)
        s_axi_rvalid && s_axi_rresp == jlr_pkg::RESP_SLVERR);

endmodule // jlr_ctrl_regs

// File: src/jlr_pkg.sv
// constants, field layouts and carrier types of the link reset and timing-reference control registers
// assumes one core clock domain and an axi4-lite master that issues aligned 32-bit accesses
//
// Functional notes
// - fixed reset bit set holds the core in reset until software clears it; default zero
// - writing one to reset bit 0 starts a core reset; reads one until finished
// - self-clearing reset keeps configuration values and restarts link using current settings
// - reset register bit 16 disables the transceiver watchdog; defaults to one
// - alignment-sequence enable, default one, makes the sequence sent or expected; zero omits it
// - scrambling register bit 0 enables scrambler or descrambler; resets to zero
// - with timing-reference-required set, resync waits for a re-alignment before the link proceeds
// - with it cleared (default), resync proceeds at the next multiframe boundary
// - four-bit delay field postpones counter re-alignment by 0 to 15 core cycles; default zero
// - with always-bit set, the counter re-aligns on every timing-reference event; events arriving while core reset is asserted are ignored
// - with always-bit clear (default), only the first event after reset re-aligns the counter
// - all registers are reached through an axi4-lite slave interface
// - transmit and receive variants share one address map and field layout
package jlr_pkg;

    // byte offsets
    localparam logic [11:0] ADDR_RESET   = 12'h004;
    localparam logic [11:0] ADDR_ALIGN   = 12'h008;
    localparam logic [11:0] ADDR_SCRAM   = 12'h00C;
    localparam logic [11:0] ADDR_TREF    = 12'h010;

    // field positions
    localparam int RST_SC_BIT     = 0;
    localparam int RST_FIX_BIT    = 1;
    localparam int RST_WD_BIT     = 16;
    localparam int ALIGN_EN_BIT   = 0;
    localparam int SCRAM_EN_BIT   = 0;
    localparam int TREF_ALW_BIT   = 0;
    localparam int TREF_DLY_LSB   = 8;
    localparam int TREF_DLY_W     = 4;
    localparam int TREF_REQ_BIT   = 16;

    // reset values
    localparam logic       RST_SC_RST   = 1'b1;
    localparam logic       RST_FIX_RST  = 1'b0;
    localparam logic       RST_WD_RST   = 1'b1;
    localparam logic       ALIGN_EN_RST = 1'b1;
    localparam logic       SCRAM_EN_RST = 1'b0;
    localparam logic       TREF_ALW_RST = 1'b0;
    localparam logic [3:0] TREF_DLY_RST = 4'h0;
    localparam logic       TREF_REQ_RST = 1'b0;

    // length of the self-clearing reset pulse, in core clock cycles
    localparam int RST_HOLD_CYCLES = 16;
    localparam int TREF_DLY_MAX    = 15;

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // link-facing configuration
    typedef struct packed {
        logic watchdog_disable;
        logic align_seq_enable;
        logic scrambler_enable;
    } jlr_cfg_t;

    // timing-reference handling configuration
    typedef struct packed {
        logic       always_realign;
        logic [3:0] delay;
    } jlr_tref_cfg_t;

    typedef enum logic [1:0] {
        sync_run,
        sync_wait_tref,
        sync_wait_lmfc
    } jlr_sync_st_t;

endpackage

// File: src/jlr_tref_align.sv
// timing-reference edge detect, first-only/always gating and programmable re-alignment delay
// assumes the timing-reference input is already synchronous to clk_sys
`timescale 1ns/100ps
module jlr_tref_align #(
    parameter int MAX_DLY = jlr_pkg::TREF_DLY_MAX
) (
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    input  wire logic                   core_rst,
    input  wire logic                   tref_in,
    input  wire jlr_pkg::jlr_tref_cfg_t cfg,
    output logic                        lmfc_realign
);

    // the tap select is four bits wide, so any other depth is refused at elaboration
    if (MAX_DLY != 15) begin : g_bad_max_dly
        $error("delay line is built for a 4-bit delay field");
    end

    typedef struct packed {
        logic                 prev;
        logic                 seen;
        logic [MAX_DLY-1:0]   pipe;
        logic                 realign;
    } jlr_tref_st_t;

    jlr_tref_st_t st_reg;
    jlr_tref_st_t st_next;
    logic         rise;
    logic         accept;

    // accepted events run down a shift line; the tap chosen by the delay field fires
    always_comb begin
        st_next      = st_reg;
        rise         = tref_in && !st_reg.prev;
        accept       = rise && !core_rst && (cfg.always_realign || !st_reg.seen);
        st_next.prev = tref_in;
        st_next.pipe = {st_reg.pipe[MAX_DLY-2:0], accept};
        if (cfg.delay == 4'h0) begin
            st_next.realign = accept;
        end else begin
            st_next.realign = st_reg.pipe[4'(cfg.delay - 4'h1)];
        end
        if (accept) begin
            st_next.seen = 1'b1;
        end
        // core reset re-arms first-event capture and drops pending events
        if (core_rst) begin
            st_next.seen    = 1'b0;
            st_next.pipe    = '0;
            st_next.realign = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lmfc_realign = st_reg.realign;

    property p_dly_zero;
        @(posedge clk_sys) disable iff (!reset_n)
        (accept && cfg.delay == 4'h0) |=> lmfc_realign;
    endproperty
    a_dly_zero: assert property (p_dly_zero) else $error("zero delay realign missing");

    property p_dly_max;
        @(posedge clk_sys) disable iff (!reset_n)
        (accept && cfg.delay == 4'hF) ##1 (!core_rst && cfg.delay == 4'hF)[*8] ##1
        (!core_rst && cfg.delay == 4'hF)[*7] |=> lmfc_realign;
    endproperty
    a_dly_max: assert property (p_dly_max) else $error("fifteen cycle delay realign missing");

    property p_always;
        @(posedge clk_sys) disable iff (!reset_n)
        (rise && cfg.always_realign && !core_rst && cfg.delay == 4'h0) |=> lmfc_realign;
    endproperty
    a_always: assert property (p_always) else $error("event ignored in always mode");

    property p_first_only;
        @(posedge clk_sys) disable iff (!reset_n)
        (st_reg.seen && !cfg.always_realign && !core_rst) |-> !accept;
    endproperty
    a_first_only: assert property (p_first_only) else $error("later event accepted");

    c_realign_dly: cover property (@(posedge clk_sys) disable iff (!reset_n)
        accept && cfg.delay == 4'h5 ##6 lmfc_realign);

endmodule // jlr_tref_align

// File: tb/jlr_ctrl_regs_tb_top.sv
// self-checking bench for the link reset and timing-reference control registers
// assumes jlr_pkg and jlr_ctrl_regs are compiled first
`timescale 1ns/100ps
module jlr_ctrl_regs_tb_top;
    localparam int RST_N = 2;
    logic              clk_sys = 1'b0;
    logic              reset_n = 1'b0;
    logic [11:0]       s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0]       s_axi_wdata = 32'h0000_0000, s_axi_rdata, r;
    logic [3:0]        s_axi_wstrb = 4'hf, d;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic              s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic              tref_in = 1'b0, lmfc_boundary = 1'b0, link_resync = 1'b0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              core_rst, align_hold, link_go, lmfc_realign;
    jlr_pkg::jlr_cfg_t link_cfg;
    logic [33:0]       exp_q[$];
    logic [1:0]        expb_q[$];
    int                n_fail = 0, checks_done = 0, cyc = 0;

    jlr_ctrl_regs #(.ADDR_W(12), .RST_CYCLES(RST_N)) u_jlr_ctrl_regs (
        .clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .tref_in, .lmfc_boundary, .link_resync, .core_rst, .link_cfg, .align_hold, .link_go, .lmfc_realign);

    initial forever #4 clk_sys = ~clk_sys;

    task automatic final_report();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_rd(logic [33:0] e, logic [33:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH read exp %h got %h", e, g);
        end
    endtask

    task automatic chk_sig(string nm, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    // a hang is cut short well past the expected run length
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            final_report();
        end
    end

    // rvalid stands one cycle with rready high, so one negedge sees it
    always @(negedge clk_sys) begin
        if (s_axi_rvalid === 1'b1 && exp_q.size() > 0) begin
            chk_rd(exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
        end
        if (s_axi_bvalid === 1'b1 && expb_q.size() > 0) begin
            chk_sig("bresp", {6'h00, expb_q.pop_front()}, {6'h00, s_axi_bresp});
        end
    end

    task automatic wr(logic [11:0] a, logic [31:0] v, logic [1:0] eb = 2'h0);
        @(negedge clk_sys);
        s_axi_awaddr = a;
        s_axi_wdata = v;
        {s_axi_awvalid, s_axi_wvalid} = 2'b11;
        expb_q.push_back(eb);
        #1 chk_sig("wready", 8'h03, {6'h00, s_axi_awready, s_axi_wready});
        @(posedge clk_sys);
        @(negedge clk_sys);
        {s_axi_awvalid, s_axi_wvalid} = 2'b00;
        @(posedge clk_sys);
    endtask

    task automatic rd(logic [11:0] a, logic [33:0] e);
        @(negedge clk_sys);
        s_axi_araddr = a;
        s_axi_arvalid = 1'b1;
        exp_q.push_back(e);
        #1 chk_sig("arready", 8'h01, {7'h00, s_axi_arready});
        @(posedge clk_sys);
        @(negedge clk_sys);
        s_axi_arvalid = 1'b0;
        @(posedge clk_sys);
    endtask

    // raise the reference and count cycles to the re-align pulse, 0 if none
    task automatic tref_evt(logic [7:0] e);
        int n;
        n = 0;
        @(negedge clk_sys);
        tref_in = 1'b1;
        for (int i = 1; i <= 20; i++) begin
            @(negedge clk_sys);
            if (lmfc_realign === 1'b1 && n == 0) n = i;
        end
        tref_in = 1'b0;
        chk_sig("realign delay", e, n[7:0]);
    endtask

    task automatic bnd(logic e);
        @(negedge clk_sys);
        lmfc_boundary = 1'b1;
        @(negedge clk_sys);
        lmfc_boundary = 1'b0;
        chk_sig("link_go", {7'h00, e}, {7'h00, link_go});
    endtask

    task automatic resync();
        @(negedge clk_sys);
        link_resync = 1'b1;
        @(negedge clk_sys);
        link_resync = 1'b0;
        chk_sig("align_hold", 8'h01, {7'h00, align_hold});
    endtask

    initial begin
        void'($urandom(62));
        repeat (16) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (RST_N + 4) @(negedge clk_sys);
        rd(12'h004, {2'h0, 32'h0001_0000});
        rd(12'h008, {2'h0, 32'h0000_0001});
        rd(12'h00C, {2'h0, 32'h0000_0000});
        rd(12'h010, {2'h0, 32'h0000_0000});
        rd(12'h014, {2'h2, 32'h0000_0000});
        chk_sig("link_cfg", 8'h06, {5'h00, link_cfg});
        // random words: only the defined bits may stick
        r = $urandom();
        wr(12'h00C, r);
        rd(12'h00C, {33'h0, r[0]});
        r = $urandom();
        wr(12'h008, r);
        rd(12'h008, {33'h0, r[0]});
        d = 4'($urandom_range(15));
        wr(12'h010, $urandom() & 32'hFFFE_F0FE | {20'h0, d, 8'h00});
        rd(12'h010, {22'h0, d, 8'h00});
        tref_evt({4'h0, d} + 8'h01);
        tref_evt(8'h00);
        // longest delay, every event re-aligns
        wr(12'h010, 32'h0000_0F01);
        tref_evt(8'h10);
        tref_evt(8'h10);
        // fixed reset holds until cleared, then the sequence finishes
        wr(12'h004, 32'h0001_0002);
        repeat (RST_N + 4) @(negedge clk_sys);
        chk_sig("core_rst", 8'h01, {7'h00, core_rst});
        rd(12'h004, {2'h0, 32'h0001_0003});
        wr(12'h004, 32'h0000_0000);
        repeat (RST_N + 2) @(negedge clk_sys);
        rd(12'h004, {2'h0, 32'h0000_0000});
        chk_sig("core_rst", 8'h00, {7'h00, core_rst});
        chk_sig("watchdog", 8'h00, {7'h00, link_cfg.watchdog_disable});
        rd(12'h010, {2'h0, 32'h0000_0F01});
        bnd(1'b1);
        resync();
        bnd(1'b1);
        wr(12'h010, 32'h0001_0001);
        resync();
        bnd(1'b0);
        tref_evt(8'h01);
        bnd(1'b1);
        // unmapped write is refused; settings survive a self-clearing reset that ends the changes
        wr(12'h014, 32'hFFFF_FFFF, 2'h2);
        wr(12'h008, 32'h0000_0001);
        wr(12'h004, 32'h0001_0001);
        rd(12'h004, {2'h0, 32'h0001_0001});
        repeat (RST_N + 2) @(negedge clk_sys);
        rd(12'h004, {2'h0, 32'h0001_0000});
        rd(12'h008, {2'h0, 32'h0000_0001});
        rd(12'h010, {2'h0, 32'h0001_0001});
        chk_sig("align_hold", 8'h01, {7'h00, align_hold});
        chk_sig("pending writes", 8'h00, 8'(expb_q.size()));
        chk_sig("pending reads", 8'h00, 8'(exp_q.size()));
        final_report();
    end
endmodule // jlr_ctrl_regs_tb_top
